// file: common/slfc_defs.svh
// Purpose: constants for the serial link flow control port
// Assumes: 5-bit sequence tags and 5-bit free buffer report fields
// Notes: timing counts are cycles of the 125 MHz clock
// Behaviour
// R1 - receiver-controlled flow control always present; transmitter-controlled mode optional
// R2 - receiver-controlled mode drives free_buffer_report all ones in every symbol
// R3 - accept error-free packet if priority space exists; send packet-accepted with tag
// R4 - packet-accepted releases retained copy and frees its buffer
// R5 - rejecting for lack of space enters input retry-stopped immediately
// R6 - packet-retry discards named packet and all later ones; resend them
// R7 - received packet-retry enters output retry-stopped and sends restart-from-retry
// R8 - first packet after restart-from-retry carries the retried tag
// R9 - sender may abort packet in flight after receiving retry
// R10 - transmitter-controlled mode never reports all ones
// R11 - report counts free max-length buffers, saturated at largest reportable value
// R12 - may under-report free buffers, never over-report
// R13 - counts travel in accepted, retry or status symbols
// R14 - send buffer-report symbols at least at the minimum symbol rate
// R15 - retry in transmitter-controlled mode still triggers output retry recovery
// R16 - input retry-stopped discards rejected packet and ignores later packets
// R17 - entering input retry-stopped makes output side send packet-retry with tag
// R18 - restart-from-retry leaves input retry-stopped and resumes reception
// R19 - output retry-stopped stops new packets and resets acknowledgment timers
// R20 - recovery sends restart-from-retry and rewinds to the retried tag
// R21 - resume with retried packet, given the tag from the retry symbol
// R22 - tags increase, wrap to zero; accept only tag previous plus one mod 32
// R23 - use transmitter-controlled mode only when both ends support it
// R24 - link-request input-status also clears input retry-stopped
// R25 - unacknowledged packets kept in a replay store ordered by tag
`ifndef SLFC_DEFS_SVH
`define SLFC_DEFS_SVH
`define SLFC_TAG_W 5
`define SLFC_BUF_W 5
`define SLFC_PRIO_W 2
`define SLFC_BUF_ALL_ONES 5'h1F
`define SLFC_BUF_MAX 5'h1E
`define SLFC_PRIO_TOP 2'h3
`define SLFC_RX_FIFO_DEPTH 16
`define SLFC_REPLAY_DEPTH 8
`define SLFC_STATUS_PERIOD_CYC 1024
`define SLFC_ACK_TIMEOUT_CYC 100000
`endif

// file: common/slfc_pkg.sv
// Purpose: types for the serial link flow control port
// Assumes: slfc_defs.svh on the include path
// Notes: symbol kinds are a plain code, states are one-hot
`include "slfc_defs.svh"
package slfc_pkg;
  typedef enum logic [2:0] {
    SYM_ACCEPTED = 3'h0,
    SYM_RETRY = 3'h1,
    SYM_NOT_ACCEPTED = 3'h2,
    SYM_STATUS = 3'h3,
    SYM_RESTART_RETRY = 3'h4,
    SYM_LINK_REQ_STATUS = 3'h5
  } slfc_sym_kind_t;

  typedef struct packed {
    slfc_sym_kind_t kind;
    logic [`SLFC_TAG_W-1:0] acked_sequence_tag;
    logic [`SLFC_BUF_W-1:0] free_buffer_report;
  } slfc_sym_t;

  typedef struct packed {
    logic [`SLFC_TAG_W-1:0] sequence_tag;
    logic [`SLFC_PRIO_W-1:0] prio;
    logic crc_ok;
    logic [31:0] data;
  } slfc_pkt_t;

  typedef struct packed {
    logic [`SLFC_PRIO_W-1:0] prio;
    logic [31:0] data;
  } slfc_word_t;

  typedef enum logic [1:0] {
    IN_RUN = 2'h1,
    IN_RETRY_STOP = 2'h2
  } slfc_in_state_t;

  typedef enum logic [1:0] {
    OUT_RUN = 2'h1,
    OUT_RETRY_STOP = 2'h2
  } slfc_out_state_t;
endpackage : slfc_pkg

// file: hw/slfc_port.sv
// Purpose: link-level flow control for one port of a serial packet link
// Assumes: one clock; link symbols and packets arrive as single-beat handshakes
// Notes: contains the receive fifo and the port top
`timescale 1ns/10ps
`default_nettype none
`include "slfc_defs.svh"

module slfc_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end
endmodule : slfc_fifo

module slfc_port #(
  parameter bit TX_CTL_SUPPORT = 1'b1,
  parameter int RX_DEPTH = `SLFC_RX_FIFO_DEPTH,
  parameter int REPLAY_DEPTH = `SLFC_REPLAY_DEPTH,
  parameter int STATUS_PERIOD = `SLFC_STATUS_PERIOD_CYC,
  parameter int ACK_TIMEOUT = `SLFC_ACK_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_pkt_valid,
  output logic rx_pkt_ready,
  input wire slfc_pkg::slfc_pkt_t rx_pkt,
  input wire logic rx_sym_valid,
  input wire slfc_pkg::slfc_sym_t rx_sym,
  output logic tx_sym_valid,
  input wire logic tx_sym_ready,
  output slfc_pkg::slfc_sym_t tx_sym,
  output logic tx_pkt_valid,
  input wire logic tx_pkt_ready,
  output slfc_pkg::slfc_pkt_t tx_pkt,
  output logic tx_pkt_abort,
  input wire logic usr_tx_valid,
  output logic usr_tx_ready,
  input wire slfc_pkg::slfc_word_t usr_tx,
  output logic usr_rx_valid,
  input wire logic usr_rx_ready,
  output slfc_pkg::slfc_word_t usr_rx,
  output logic tx_ctl_mode,
  output logic in_retry_stopped,
  output logic out_retry_stopped,
  output logic ack_timeout
);
  import slfc_pkg::*;

  localparam int TW = `SLFC_TAG_W;
  localparam int RA = $clog2(REPLAY_DEPTH);
  localparam int CW = $clog2(RX_DEPTH+1);
  localparam int SW = $clog2(STATUS_PERIOD+1);
  localparam int AW = $clog2(ACK_TIMEOUT+1);

  slfc_in_state_t in_state;
  slfc_out_state_t out_state;

  // receive side
  logic [TW-1:0] rx_exp_tag;
  logic [CW-1:0] rx_count;
  logic [CW:0] rx_free;
  logic rx_space;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic rx_take;
  logic rx_good;
  logic rx_accept;
  logic rx_reject;
  logic restart_in;
  logic [`SLFC_BUF_W-1:0] report;

  // symbol scheduling
  logic pend_acc;
  logic [TW-1:0] pend_acc_tag;
  logic pend_retry;
  logic [TW-1:0] pend_retry_tag;
  logic pend_restart;
  logic pend_status;
  logic sym_load;
  logic [SW-1:0] status_cnt;

  // transmit side
  slfc_word_t replay [REPLAY_DEPTH];
  logic [TW-1:0] ack_tag;
  logic [TW-1:0] send_tag;
  logic [TW-1:0] wr_tag;
  logic [TW-1:0] in_store;
  logic retry_in;
  logic accepted_in;
  logic pkt_load;
  logic [AW-1:0] ack_cnt;

  assign in_retry_stopped = (in_state == IN_RETRY_STOP);
  assign out_retry_stopped = (out_state == OUT_RETRY_STOP);

  // priority-level space: each lower priority leaves one more slot free
  assign rx_free = (CW+1)'(RX_DEPTH) - {1'b0, rx_count};
  assign rx_space = rx_free > (CW+1)'(`SLFC_PRIO_TOP - rx_pkt.prio);
  assign rx_pkt_ready = !pend_acc && !pend_retry;
  assign rx_take = rx_pkt_valid && rx_pkt_ready;
  assign rx_good = rx_take && (in_state == IN_RUN) && rx_pkt.crc_ok
    && (rx_pkt.sequence_tag == rx_exp_tag); // R22
  assign rx_accept = rx_good && rx_space && fifo_in_ready; // R3
  assign rx_reject = rx_good && !(rx_space && fifo_in_ready); // R5
  assign fifo_in_valid = rx_accept;
  assign restart_in = rx_sym_valid
    && (rx_sym.kind == SYM_RESTART_RETRY || rx_sym.kind == SYM_LINK_REQ_STATUS); // R18 R24

  slfc_fifo #(
    .W($bits(slfc_word_t)),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({rx_pkt.prio, rx_pkt.data}),
    .out_valid(usr_rx_valid),
    .out_ready(usr_rx_ready),
    .out_data(usr_rx),
    .count(rx_count)
  );

  // input retry-stopped machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_state <= IN_RUN;
      rx_exp_tag <= '0;
    end else begin
      case (in_state)
        IN_RUN: begin
          if (rx_accept) begin
            rx_exp_tag <= rx_exp_tag + TW'(1); // R22
          end
          if (rx_reject) begin
            in_state <= IN_RETRY_STOP; // R5
          end
        end
        IN_RETRY_STOP: begin
          // packets are dropped here by rx_good being low R16
          if (restart_in) begin
            in_state <= IN_RUN; // R18 R24
          end
        end
        default: begin
          in_state <= IN_RUN;
        end
      endcase
    end
  end

  // flow control mode follows what the partner advertises
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ctl_mode <= 1'b0; // R1
    end else if (rx_sym_valid && rx_sym.kind == SYM_STATUS) begin
      tx_ctl_mode <= TX_CTL_SUPPORT
        && (rx_sym.free_buffer_report != `SLFC_BUF_ALL_ONES); // R23
    end
  end

  // free buffer report: all ones in receiver-controlled mode, else never exceeds actual free slots R12
  always_comb begin
    if (!tx_ctl_mode) begin
      report = `SLFC_BUF_ALL_ONES; // R2
    end else if (rx_free > (CW+1)'(`SLFC_BUF_MAX)) begin
      report = `SLFC_BUF_MAX; // R10 R11
    end else begin
      report = `SLFC_BUF_W'(rx_free); // R11 R12
    end
  end

  // symbol output register, one symbol at a time
  assign sym_load = (!tx_sym_valid || tx_sym_ready)
    && (pend_retry || pend_restart || pend_acc || pend_status);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_sym_valid <= 1'b0;
      tx_sym <= '{kind: SYM_STATUS, acked_sequence_tag: '0, free_buffer_report: '1};
    end else if (sym_load) begin
      tx_sym_valid <= 1'b1;
      tx_sym.free_buffer_report <= report; // R13
      if (pend_retry) begin
        tx_sym.kind <= SYM_RETRY; // R17
        tx_sym.acked_sequence_tag <= pend_retry_tag;
      end else if (pend_restart) begin
        tx_sym.kind <= SYM_RESTART_RETRY; // R7 R20
        tx_sym.acked_sequence_tag <= send_tag;
      end else if (pend_acc) begin
        tx_sym.kind <= SYM_ACCEPTED; // R3
        tx_sym.acked_sequence_tag <= pend_acc_tag;
      end else begin
        tx_sym.kind <= SYM_STATUS; // R14
        tx_sym.acked_sequence_tag <= rx_exp_tag;
      end
    end else if (tx_sym_ready) begin
      tx_sym_valid <= 1'b0;
    end
  end

  // pending symbol flags; a set in the same cycle wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_retry <= 1'b0;
      pend_retry_tag <= '0;
      pend_restart <= 1'b0;
      pend_acc <= 1'b0;
      pend_acc_tag <= '0;
    end else begin
      if (sym_load) begin
        if (pend_retry) begin
          pend_retry <= 1'b0;
        end else if (pend_restart) begin
          pend_restart <= 1'b0;
        end else if (pend_acc) begin
          pend_acc <= 1'b0;
        end
      end
      if (rx_reject) begin
        pend_retry <= 1'b1; // R17
        pend_retry_tag <= rx_pkt.sequence_tag;
      end
      if (retry_in) begin
        pend_restart <= 1'b1; // R7 R15 R20
      end
      if (rx_accept) begin
        pend_acc <= 1'b1; // R3
        pend_acc_tag <= rx_pkt.sequence_tag;
      end
    end
  end

  // periodic status so the report is never older than the period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_cnt <= '0;
      pend_status <= 1'b0;
    end else if (sym_load) begin
      status_cnt <= '0; // R14
      pend_status <= 1'b0;
    end else if (status_cnt == SW'(STATUS_PERIOD)) begin
      pend_status <= 1'b1; // R14
    end else begin
      status_cnt <= status_cnt + SW'(1);
    end
  end

  // transmit side: replay store indexed by tag R25
  assign retry_in = rx_sym_valid && rx_sym.kind == SYM_RETRY; // R6
  assign accepted_in = rx_sym_valid && rx_sym.kind == SYM_ACCEPTED
    && rx_sym.acked_sequence_tag == ack_tag && ack_tag != send_tag;
  assign in_store = wr_tag - ack_tag;
  assign usr_tx_ready = in_store < TW'(REPLAY_DEPTH);
  assign pkt_load = (out_state == OUT_RUN) && !retry_in
    && (!tx_pkt_valid || tx_pkt_ready) && (send_tag != wr_tag); // R19

  always_ff @(posedge clk) begin
    if (usr_tx_valid && usr_tx_ready) begin
      replay[wr_tag[RA-1:0]] <= usr_tx; // R25
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_tag <= '0;
      ack_tag <= '0;
    end else begin
      if (usr_tx_valid && usr_tx_ready) begin
        wr_tag <= wr_tag + TW'(1); // R22
      end
      if (accepted_in) begin
        ack_tag <= ack_tag + TW'(1); // R4
      end
    end
  end

  // output retry-stopped machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_state <= OUT_RUN;
      send_tag <= '0;
    end else begin
      case (out_state)
        OUT_RUN: begin
          if (retry_in) begin
            out_state <= OUT_RETRY_STOP; // R7 R15 R19
            send_tag <= rx_sym.acked_sequence_tag; // R20
          end else if (pkt_load) begin
            send_tag <= send_tag + TW'(1);
          end
        end
        OUT_RETRY_STOP: begin
          if (retry_in) begin
            send_tag <= rx_sym.acked_sequence_tag; // R20
          end else if (!pend_restart) begin
            out_state <= OUT_RUN; // R8 R21
          end
        end
        default: begin
          out_state <= OUT_RUN;
        end
      endcase
    end
  end

  // packet output register; a retry drops the packet still offered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_pkt_valid <= 1'b0;
      tx_pkt <= '0;
      tx_pkt_abort <= 1'b0;
    end else begin
      tx_pkt_abort <= retry_in && tx_pkt_valid && !tx_pkt_ready; // R9
      if (retry_in) begin
        tx_pkt_valid <= 1'b0; // R9 R19
      end else if (pkt_load) begin
        tx_pkt_valid <= 1'b1;
        tx_pkt.sequence_tag <= send_tag; // R8 R21
        tx_pkt.prio <= replay[send_tag[RA-1:0]].prio;
        tx_pkt.data <= replay[send_tag[RA-1:0]].data;
        tx_pkt.crc_ok <= 1'b1;
      end else if (tx_pkt_ready) begin
        tx_pkt_valid <= 1'b0;
      end
    end
  end

  // acknowledgment timer for the oldest unaccepted packet
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_cnt <= '0;
      ack_timeout <= 1'b0;
    end else begin
      ack_timeout <= 1'b0;
      if (retry_in || accepted_in || out_state != OUT_RUN || ack_tag == send_tag) begin
        ack_cnt <= '0; // R19
      end else if (ack_cnt == AW'(ACK_TIMEOUT)) begin
        ack_timeout <= 1'b1;
        ack_cnt <= '0;
      end else begin
        ack_cnt <= ack_cnt + AW'(1);
      end
    end
  end
endmodule : slfc_port
`default_nettype wire

// file: tb/slfc_port_props.sv
// Purpose: concurrent checks on the ports of slfc_port
// Assumes: bound from tb_slfc_port
// Notes: one clock domain, reset disables every check
`timescale 1ns/10ps
`default_nettype none
module slfc_port_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_pkt_valid,
  input wire logic rx_pkt_ready,
  input wire slfc_pkg::slfc_pkt_t rx_pkt,
  input wire logic rx_sym_valid,
  input wire slfc_pkg::slfc_sym_t rx_sym,
  input wire logic tx_sym_valid,
  input wire slfc_pkg::slfc_sym_t tx_sym,
  input wire logic tx_pkt_valid,
  input wire slfc_pkg::slfc_pkt_t tx_pkt,
  input wire logic tx_ctl_mode,
  input wire logic in_retry_stopped,
  input wire logic out_retry_stopped
);
  import slfc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic armed;
  logic [4:0] rtag;
  // remembers the last retried tag until the next launch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
      rtag <= 5'h00;
    end else if (rx_sym_valid && rx_sym.kind == SYM_RETRY) begin
      armed <= 1'b1;
      rtag <= rx_sym.acked_sequence_tag;
    end else if (tx_pkt_valid) begin
      armed <= 1'b0;
    end
  end
  a_rx_mode_ones: assert property (
    tx_sym_valid && !tx_ctl_mode && !$past(tx_ctl_mode) |-> tx_sym.free_buffer_report == 5'h1F)
    else $error("report not all ones in receiver mode");
  a_tx_mode_count: assert property (
    tx_sym_valid && tx_ctl_mode && $past(tx_ctl_mode) |-> tx_sym.free_buffer_report != 5'h1F)
    else $error("all ones report in transmitter mode");
  a_accept_tag: assert property (
    rx_pkt_valid && rx_pkt_ready |=> ##1 !(tx_sym_valid && tx_sym.kind == SYM_ACCEPTED)
    || tx_sym.acked_sequence_tag == $past(rx_pkt.sequence_tag, 2))
    else $error("accepted symbol names wrong tag");
  a_retry_enter: assert property (
    $rose(in_retry_stopped) |=> tx_sym_valid && tx_sym.kind == SYM_RETRY
    && tx_sym.acked_sequence_tag == $past(rx_pkt.sequence_tag, 2))
    else $error("retry symbol missing on input stop");
  a_stop_ignores: assert property (
    in_retry_stopped && rx_pkt_valid && rx_pkt_ready |=> ##1 !(tx_sym_valid
    && tx_sym.kind == SYM_ACCEPTED))
    else $error("packet accepted while input stopped");
  a_stop_leave: assert property (
    in_retry_stopped && rx_sym_valid && (rx_sym.kind == SYM_RESTART_RETRY
    || rx_sym.kind == SYM_LINK_REQ_STATUS) |=> !in_retry_stopped)
    else $error("input stop not left");
  a_out_stop: assert property (
    rx_sym_valid && rx_sym.kind == SYM_RETRY |=> out_retry_stopped && !tx_pkt_valid)
    else $error("output not stopped on retry");
  a_restart_sent: assert property (
    rx_sym_valid && rx_sym.kind == SYM_RETRY |-> ##[1:40] (tx_sym_valid
    && tx_sym.kind == SYM_RESTART_RETRY && tx_sym.acked_sequence_tag == rtag))
    else $error("restart symbol not sent");
  a_resume_tag: assert property (
    armed && tx_pkt_valid |-> tx_pkt.sequence_tag == rtag)
    else $error("resumed packet has wrong tag");
endmodule : slfc_port_props
`default_nettype wire

// file: tb/slfc_link_partner.sv
// Purpose: behavioural far end of the serial link
// Assumes: receiver-controlled mode, symbols injected by the bench
// Notes: stall holds off packets, symbols and acknowledgements
`timescale 1ns/10ps
`default_nettype none
module slfc_link_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic inj_valid,
  input wire slfc_pkg::slfc_sym_t inj,
  input wire logic tx_pkt_valid,
  output logic tx_pkt_ready,
  input wire slfc_pkg::slfc_pkt_t tx_pkt,
  output logic tx_sym_ready,
  output logic rx_sym_valid,
  output slfc_pkg::slfc_sym_t rx_sym,
  output logic [7:0] n_pkts,
  output logic [7:0] n_bad
);
  import slfc_pkg::*;
  logic [4:0] q [$];
  logic [4:0] exp_tag;
  assign tx_pkt_ready = !stall;
  assign tx_sym_ready = !stall;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      q.delete();
      exp_tag <= 5'h00;
      n_pkts <= 8'h00;
      n_bad <= 8'h00;
      rx_sym_valid <= 1'b0;
      rx_sym <= '0;
    end else begin
      if (tx_pkt_valid && tx_pkt_ready) begin
        n_pkts <= n_pkts + 8'h01;
        if (tx_pkt.sequence_tag !== exp_tag) n_bad <= n_bad + 8'h01;
        exp_tag <= tx_pkt.sequence_tag + 5'h01;
        q.push_back(tx_pkt.sequence_tag);
      end
      rx_sym_valid <= 1'b1;
      if (inj_valid) begin
        rx_sym <= inj;
        if (inj.kind == SYM_RETRY) begin
          q.delete();
          exp_tag <= inj.acked_sequence_tag;
        end
      end else if (q.size() > 0 && !stall) begin
        rx_sym <= '{SYM_ACCEPTED, q.pop_front(), 5'h1F};
      end else begin
        rx_sym_valid <= 1'b0;
        rx_sym <= slfc_sym_t'(~rx_sym);
      end
    end
  end
endmodule : slfc_link_partner
`default_nettype wire

// file: tb/tb_slfc_port.sv
// Purpose: self-checking bench for slfc_port
// Assumes: partner answers every launched packet unless stalled
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_slfc_port;
  import slfc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rx_pkt_valid, rx_pkt_ready, rx_sym_valid, tx_sym_valid, tx_sym_ready;
  logic tx_pkt_valid, tx_pkt_ready, tx_pkt_abort, usr_tx_valid, usr_tx_ready;
  logic usr_rx_valid, usr_rx_ready, tx_ctl_mode, in_retry_stopped, out_retry_stopped;
  logic stall, inj_valid, ack_timeout;
  slfc_pkt_t rx_pkt, tx_pkt;
  slfc_sym_t rx_sym, tx_sym, inj;
  slfc_word_t usr_tx, usr_rx;
  logic [7:0] n_pkts, n_bad;
  logic [4:0] rt;
  int fails, n_tests, n_tmo;
  always #4 clk = ~clk;
  // counts acknowledgment timeout pulses
  always @(negedge clk) begin
    if (ack_timeout === 1'b1) n_tmo++;
  end
  slfc_port #(.STATUS_PERIOD(256), .ACK_TIMEOUT(50)) i_slfc_port (.clk, .reset,
    .rx_pkt_valid, .rx_pkt_ready, .rx_pkt, .rx_sym_valid, .rx_sym, .tx_sym_valid,
    .tx_sym_ready, .tx_sym, .tx_pkt_valid, .tx_pkt_ready, .tx_pkt, .tx_pkt_abort,
    .usr_tx_valid, .usr_tx_ready, .usr_tx, .usr_rx_valid, .usr_rx_ready, .usr_rx,
    .tx_ctl_mode, .in_retry_stopped, .out_retry_stopped, .ack_timeout);
  slfc_link_partner i_slfc_link_partner (.clk, .reset, .stall, .inj_valid, .inj,
    .tx_pkt_valid, .tx_pkt_ready, .tx_pkt, .tx_sym_ready, .rx_sym_valid, .rx_sym,
    .n_pkts, .n_bad);
  task automatic final_report();
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_sym(input slfc_sym_t exp);
    n_tests++;
    if (tx_sym_valid !== 1'b1 || tx_sym !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, tx_sym, exp);
    end
  endtask : chk_sym
  task automatic wait_hi(const ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) chk_val(32'h0, 32'h1);
  endtask : wait_hi
  task automatic send_rx(input logic [4:0] tag, input logic [1:0] pr, input logic [31:0] d);
    @(negedge clk);
    rx_pkt_valid = 1'b1;
    rx_pkt = '{tag, pr, 1'b1, d};
    wait_hi(rx_pkt_ready);
    @(negedge clk);
    rx_pkt_valid = 1'b0;
    rx_pkt = slfc_pkt_t'(~rx_pkt);
    // the answering symbol is loaded one cycle after the take
    @(negedge clk);
  endtask : send_rx
  task automatic send_usr(input logic [31:0] d);
    @(negedge clk);
    usr_tx_valid = 1'b1;
    usr_tx = '{2'h0, d};
    wait_hi(usr_tx_ready);
    @(negedge clk);
    usr_tx_valid = 1'b0;
    usr_tx = slfc_word_t'(~usr_tx);
  endtask : send_usr
  task automatic inject(input slfc_sym_kind_t k, input logic [4:0] tag, input logic [4:0] rep);
    @(negedge clk);
    inj_valid = 1'b1;
    inj = '{k, tag, rep};
    @(negedge clk);
    inj_valid = 1'b0;
  endtask : inject
  task automatic t_out_stream();
    for (int i = 0; i < 12; i++) send_usr(32'(i));
    repeat (20) @(negedge clk);
    chk_val(n_pkts, 8'h0C);
    chk_val(n_bad, 8'h00);
  endtask : t_out_stream
  task automatic t_rx_flow(input slfc_sym_kind_t k);
    send_rx(rt + 5'h02, 2'h3, 32'h0);
    chk_val(tx_sym_valid, 1'b0);
    usr_rx_ready = 1'b0;
    for (int i = 0; i < 14; i++) begin
      send_rx(rt, 2'h0, 32'(i));
      if (i < 13) begin
        chk_sym('{SYM_ACCEPTED, rt, 5'h1F});
        rt++;
      end
    end
    chk_sym('{SYM_RETRY, rt, 5'h1F});
    chk_val(in_retry_stopped, 1'b1);
    send_rx(rt, 2'h3, 32'h0);
    chk_val(tx_sym_valid, 1'b0);
    inject(k, rt, 5'h1F);
    repeat (3) @(negedge clk);
    chk_val(in_retry_stopped, 1'b0);
    usr_rx_ready = 1'b1;
    for (int i = 0; i < 13; i++) begin
      wait_hi(usr_rx_valid);
      chk_val(usr_rx.data, 32'(i));
      @(negedge clk);
    end
    send_rx(rt, 2'h3, 32'h0);
    chk_sym('{SYM_ACCEPTED, rt, 5'h1F});
    rt++;
  endtask : t_rx_flow
  task automatic t_mode();
    inject(SYM_STATUS, 5'h00, 5'h05);
    @(negedge clk);
    chk_val(tx_ctl_mode, 1'b1);
    send_rx(rt, 2'h3, 32'h0);
    chk_val({tx_sym.kind, tx_sym.acked_sequence_tag}, {SYM_ACCEPTED, rt});
    chk_val(tx_sym.free_buffer_report inside {5'h0F, 5'h10}, 1'b1);
    rt++;
  endtask : t_mode
  task automatic t_retry_out();
    stall = 1'b1;
    for (int i = 0; i < 3; i++) send_usr(32'h100 + 32'(i));
    // one unanswered packet for longer than one timeout span
    repeat (60) @(negedge clk);
    chk_val(n_tmo, 32'h1);
    inject(SYM_RETRY, 5'h0C, 5'h1F);
    @(negedge clk);
    chk_val(out_retry_stopped, 1'b1);
    chk_val(tx_pkt_abort, 1'b1);
    chk_val(tx_pkt_valid, 1'b0);
    stall = 1'b0;
    repeat (40) @(negedge clk);
    chk_val(n_pkts, 8'h0F);
    chk_val(n_bad, 8'h00);
    chk_val(n_tmo, 32'h1);
  endtask : t_retry_out
  initial begin
    rx_pkt_valid = 1'b0;
    usr_tx_valid = 1'b0;
    stall = 1'b0;
    inj_valid = 1'b0;
    usr_rx_ready = 1'b1;
    rx_pkt = '0;
    usr_tx = '0;
    inj = '0;
    rt = 5'h00;
    fails = 0;
    n_tests = 0;
    n_tmo = 0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_out_stream();
    t_rx_flow(SYM_RESTART_RETRY);
    t_rx_flow(SYM_LINK_REQ_STATUS);
    t_rx_flow(SYM_RESTART_RETRY);
    t_mode();
    t_retry_out();
    final_report();
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule : tb_slfc_port
bind slfc_port slfc_port_props i_slfc_port_props (.clk, .reset, .rx_pkt_valid,
  .rx_pkt_ready, .rx_pkt, .rx_sym_valid, .rx_sym, .tx_sym_valid, .tx_sym, .tx_pkt_valid,
  .tx_pkt, .tx_ctl_mode, .in_retry_stopped, .out_retry_stopped);
`default_nettype wire
